/* logic/pump_reporter.sv */
// Pump status and digital I/O command handler with a Wishbone register slave.
//
// Behaviour
// - Input query samples the trigger input and replies Low. or High.
// - Output command with port 1 and high or low drives the output port.
// - Status line: three integers, one flag field, single spaces, ends CR LF.
// - First integer is the present rate in femtoliters per second.
// - Second integer is run time in milliseconds, counted at one millisecond.
// - Third integer is the dispensed volume in femtoliters.
// - Rate, time and volume follow the currently selected direction.
// - Flag field holds exactly six single characters.
// - Flag one is i or w, upper case while the motor runs.
// - Flag two shows the hit limit switch as i or w, else a period.
// - Flag three is S when stalled, otherwise a period.
// - Flag four is T while trigger input is high, period when low.
// - Flag five shows the direction port as i or w.
// - Flag six is T once target time or volume reached, else period.
// - Remote mode drops prompts and CR, always shows address, no echo.
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "pump_consts.svh"
module pump_reporter
  import pump_pkg::*;
#(
  parameter int unsigned MS_TICKS = `MS_TICKS_CALC
) (
  input  wire logic        clk_i,        // Clock, 200 MHz.
  input  wire logic        rst_i,        // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,     // Wishbone cycle.
  input  wire logic        wb_stb_i,     // Wishbone strobe.
  input  wire logic        wb_we_i,      // Wishbone write enable.
  input  wire logic [7:0]  wb_adr_i,     // Wishbone byte address.
  input  wire logic [3:0]  wb_sel_i,     // Wishbone byte selects.
  input  wire logic [31:0] wb_dat_i,     // Wishbone write data.
  output logic      [31:0] wb_dat_o,     // Wishbone read data.
  output logic             wb_ack_o,     // Wishbone acknowledge.
  input  wire logic [7:0]  rx_data_i,    // Command character from host.
  input  wire logic        rx_valid_i,   // Command character valid.
  output logic             rx_ready_o,   // Ready to take a character.
  output logic      [7:0]  tx_data_o,    // Reply character.
  output logic             tx_valid_o,   // Reply character valid.
  input  wire logic        tx_ready_i,   // Host side takes the character.
  input  wire logic [31:0] rate_inf_i,   // Infuse rate, fl/s.
  input  wire logic [31:0] rate_wdr_i,   // Withdraw rate, fl/s.
  input  wire logic [31:0] vol_inf_i,    // Infused volume, fl.
  input  wire logic [31:0] vol_wdr_i,    // Withdrawn volume, fl.
  input  wire logic        motor_dir_i,  // Selected direction, 1 is withdraw.
  input  wire logic        motor_run_i,  // Motor running.
  input  wire logic        limit_inf_i,  // Infuse limit switch hit.
  input  wire logic        limit_wdr_i,  // Withdraw limit switch hit.
  input  wire logic        stall_i,      // Pump stalled.
  input  wire logic        trigger_i,    // Trigger input level.
  input  wire logic        dir_port_i,   // Direction port, 1 is withdraw.
  input  wire logic        target_hit_i, // Target time or volume reached.
  output logic             out_port_o,   // Digital output port 1.
  output logic             irq_o         // Interrupt, active high level.
);
  // ==========================================================================
  // Sub-blocks
  cmd_if cmd ();
  dec_if dec ();

  state_t state_r;
  state_t state_nxt;

  wire rx_take = rx_valid_i & rx_ready_o;
  // The last reply character must be handed over first, so a new line never overlaps a reply.
  assign rx_ready_o = (state_r == ST_IDLE) & ~tx_valid_r;

  pump_parser u_parser (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .rx_data_i (rx_data_i),
    .rx_take_i (rx_take),
    .link      (cmd)
  );

  pump_decimal u_decimal (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .port  (dec)
  );

  // ==========================================================================
  // Register bus
  logic                  ack_r;
  logic [31:0]           dat_r;
  logic                  remote_r;
  logic [7:0]            addr_r;
  logic [`IRQ_WIDTH-1:0] irq_stat_r;
  logic [`IRQ_WIDTH-1:0] irq_mask_r;
  logic [`IRQ_WIDTH-1:0] irq_ev;
  logic                  out_r;
  logic [31:0]           time_r [2];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = ({a[7:2], 2'b00} == r);
  endfunction

  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wb_wr  = wb_req & wb_we_i;
  wire wb_rd  = wb_req & ~wb_we_i;
  wire stat_rd = wb_rd & hit(wb_adr_i, `REG_IRQ_STAT);
  wire ctrl_wr = wb_wr & hit(wb_adr_i, `REG_CTRL);
  wire mask_wr = wb_wr & hit(wb_adr_i, `REG_IRQ_MASK) & wb_sel_i[0];
  wire [1:0] time_clr = (wb_wr & hit(wb_adr_i, `REG_TIME_CLR) & wb_sel_i[0]) ?
                        wb_dat_i[1:0] : 2'b00;

  wire [31:0] rdata =
    hit(wb_adr_i, `REG_CTRL)     ? {16'h0000, addr_r, 7'h00, remote_r} :
    hit(wb_adr_i, `REG_IRQ_STAT) ? {29'h0000_0000, irq_stat_r} :
    hit(wb_adr_i, `REG_IRQ_MASK) ? {29'h0000_0000, irq_mask_r} :
    hit(wb_adr_i, `REG_IO_STAT)  ? {28'h000_0000, motor_dir_i, motor_run_i, trigger_i, out_r} :
    hit(wb_adr_i, `REG_TIME_INF) ? time_r[0] :
    hit(wb_adr_i, `REG_TIME_WDR) ? time_r[1] : 32'h0000_0000;

  // Every access, mapped or not, is answered one cycle after the strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      dat_r <= wb_rd ? rdata : dat_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remote_r   <= `REMOTE_RESET;
      addr_r     <= `ADDR_RESET;
      irq_mask_r <= '0;
    end else begin
      if (ctrl_wr & wb_sel_i[0]) begin
        remote_r <= wb_dat_i[`CTRL_REMOTE_BIT];
      end
      if (ctrl_wr & wb_sel_i[1]) begin
        addr_r <= wb_dat_i[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
      end
      if (mask_wr) begin
        irq_mask_r <= wb_dat_i[`IRQ_WIDTH-1:0];
      end
    end
  end

  // A read clears the status, but an event in the same cycle still lands.
  wire [`IRQ_WIDTH-1:0] irq_stat_nxt = (stat_rd ? '0 : irq_stat_r) | irq_ev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  assign irq_o    = |(irq_stat_r & irq_mask_r);
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ==========================================================================
  // Run time per direction
  logic [31:0] tick_r;
  wire         ms_tick = motor_run_i & (tick_r == 32'(MS_TICKS - 1));

  // The tick only advances while running, so partial milliseconds carry over stops.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_r <= 32'h0000_0000;
    end else if (ms_tick) begin
      tick_r <= 32'h0000_0000;
    end else if (motor_run_i) begin
      tick_r <= tick_r + 32'h0000_0001;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_time
    wire dir_match = (motor_dir_i == 1'(g));
    always_ff @(posedge clk_i) begin
      if (rst_i | time_clr[g]) begin
        time_r[g] <= 32'h0000_0000;
      end else if (ms_tick & dir_match) begin
        time_r[g] <= time_r[g] + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Command handling and reply snapshot
  logic        is_status_r;
  logic        is_bad_r;
  logic        high_r;
  logic [7:0]  flags_r;
  val_t        rate_r;
  val_t        ms_r;
  val_t        vol_r;
  logic [2:0]  step_r;
  logic [1:0]  field_r;

  wire accept = (state_r == ST_IDLE) & cmd.valid;
  wire out_set = accept & ((cmd.code == CMD_OUT_HI) | (cmd.code == CMD_OUT_LO));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_r <= `OUT_RESET;
    end else if (out_set) begin
      out_r <= (cmd.code == CMD_OUT_HI);
    end
  end
  assign out_port_o = out_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      is_status_r <= 1'b0;
      is_bad_r    <= 1'b0;
      high_r      <= 1'b0;
      flags_r     <= 8'h00;
      rate_r      <= '0;
      ms_r        <= '0;
      vol_r       <= '0;
    end else if (accept) begin
      is_status_r <= (cmd.code == CMD_STATUS);
      is_bad_r    <= (cmd.code == CMD_BAD);
      high_r      <= trigger_i;
      // One capture for everything the line reports.
      flags_r <= {target_hit_i, dir_port_i, trigger_i, stall_i,
                  limit_wdr_i, limit_inf_i, motor_dir_i, motor_run_i};
      rate_r  <= motor_dir_i ? rate_wdr_i : rate_inf_i;
      ms_r    <= time_r[motor_dir_i];
      vol_r   <= motor_dir_i ? vol_wdr_i : vol_inf_i;
    end
  end

  // Direction letters follow the motor run state for case, as flag one does.
  function automatic logic [7:0] dir_char(input logic wdr, input logic run);
    dir_char = wdr ? (run ? "W" : "w") : (run ? "I" : "i");
  endfunction

  function automatic logic [7:0] flag_char(input logic [2:0] i, input logic [7:0] f);
    case (i)
      3'h0:    flag_char = dir_char(f[1], f[0]);
      3'h1:    flag_char = f[2] ? dir_char(1'b0, f[0]) :
                           f[3] ? dir_char(1'b1, f[0]) : ".";
      3'h2:    flag_char = f[4] ? "S" : ".";
      3'h3:    flag_char = f[5] ? "T" : ".";
      3'h4:    flag_char = dir_char(f[6], f[0]);
      default: flag_char = f[7] ? "T" : ".";
    endcase
  endfunction

  function automatic logic [7:0] text_char(input logic bad, input logic hi, input logic [2:0] i);
    case ({bad, hi, i})
      5'h00:   text_char = "L";
      5'h01:   text_char = "o";
      5'h02:   text_char = "w";
      5'h08:   text_char = "H";
      5'h09:   text_char = "i";
      5'h0A:   text_char = "g";
      5'h0B:   text_char = "h";
      5'h03,
      5'h0C:   text_char = ".";
      default: text_char = "?";
    endcase
  endfunction

  // ==========================================================================
  // Reply sequencer
  logic       tx_valid_r;
  logic [7:0] tx_data_r;
  logic       cur_ok;
  logic [7:0] cur_char;
  logic       cur_last;

  wire       show_addr = remote_r | (addr_r != 8'h00);
  wire [7:0] tens      = 8'h30 + 8'((addr_r / 8'd10) % 8'd10);
  wire [7:0] units     = 8'h30 + 8'(addr_r % 8'd10);
  wire       can_load  = ~tx_valid_r | tx_ready_i;
  wire       st_num    = (state_r == ST_NUM);
  wire       num_load  = st_num & dec.dvalid & can_load;
  wire       char_st   = (state_r == ST_HEAD) | (state_r == ST_TEXT) | (state_r == ST_SPACE) |
                         (state_r == ST_FLAG) | (state_r == ST_END);
  wire       advance   = char_st & (~cur_ok | can_load);
  wire       tx_load   = (char_st & cur_ok & can_load) | num_load;

  always_comb begin
    cur_ok   = 1'b1;
    cur_char = " ";
    cur_last = 1'b1;
    case (state_r)
      ST_HEAD: begin
        cur_last = (step_r == 3'h4);
        case (step_r)
          3'h0:    begin cur_char = 8'h0A; cur_ok = ~is_status_r; end
          3'h1:    begin cur_char = tens;  cur_ok = show_addr;    end
          3'h2:    begin cur_char = units; cur_ok = show_addr;    end
          3'h3:    begin cur_char = ":";   cur_ok = show_addr;    end
          default: begin cur_char = " ";   cur_ok = show_addr & ~is_status_r; end
        endcase
      end
      ST_TEXT: begin
        cur_char = text_char(is_bad_r, high_r, step_r);
        cur_last = is_bad_r | (step_r == (high_r ? 3'h4 : 3'h3));
      end
      ST_FLAG: begin
        cur_char = flag_char(step_r, flags_r);
        cur_last = (step_r == 3'h5);
      end
      ST_END: begin
        // A status line ends CR LF, other replies end CR alone; remote mode drops the CR.
        cur_char = (step_r == 3'h0) ? 8'h0D : 8'h0A;
        cur_ok   = (step_r == 3'h0) ? ~remote_r : is_status_r;
        cur_last = (step_r == 3'h1);
      end
      default: begin
        cur_ok = (state_r == ST_SPACE);
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept & (cmd.code != CMD_NONE) & ~out_set) begin
          state_nxt = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (advance & cur_last) begin
          state_nxt = is_status_r ? ST_NSTART : ST_TEXT;
        end
      end
      ST_TEXT: begin
        if (advance & cur_last) begin
          state_nxt = ST_END;
        end
      end
      ST_NSTART: begin
        state_nxt = ST_NUM;
      end
      ST_NUM: begin
        if (num_load & dec.dlast) begin
          state_nxt = ST_SPACE;
        end
      end
      ST_SPACE: begin
        if (advance) begin
          state_nxt = (field_r == 2'h2) ? ST_FLAG : ST_NSTART;
        end
      end
      ST_FLAG: begin
        if (advance & cur_last) begin
          state_nxt = ST_END;
        end
      end
      ST_END: begin
        if (advance & cur_last) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      step_r  <= 3'h0;
      field_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      step_r  <= (state_nxt != state_r) ? 3'h0 : (advance ? step_r + 3'h1 : step_r);
      if (state_r == ST_IDLE) begin
        field_r <= 2'h0;
      end else if ((state_r == ST_SPACE) & advance) begin
        field_r <= field_r + 2'h1;
      end
    end
  end

  // Integers are fed one after another to the converter, unpadded.
  assign dec.start  = (state_r == ST_NSTART);
  assign dec.value  = (field_r == 2'h0) ? rate_r : (field_r == 2'h1) ? ms_r : vol_r;
  assign dec.dready = st_num & can_load;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
    end else if (tx_load) begin
      tx_valid_r <= 1'b1;
      tx_data_r  <= num_load ? dec.digit : cur_char;
    end else if (tx_ready_i) begin
      tx_valid_r <= 1'b0;
    end
  end

  assign tx_valid_o = tx_valid_r;
  assign tx_data_o  = tx_data_r;

  assign irq_ev[`IRQ_REPLY_BIT] = (state_r == ST_END) & advance & cur_last;
  assign irq_ev[`IRQ_BAD_BIT]   = accept & (cmd.code == CMD_BAD);
  assign irq_ev[`IRQ_OUT_BIT]   = out_set;
endmodule
`default_nettype wire

/* common/pump_consts.svh */
// Register offsets, field positions, reset values and timing counts of the pump reporter.
`ifndef PUMP_CONSTS_SVH
`define PUMP_CONSTS_SVH
`define REG_CTRL        8'h00
`define REG_TIME_CLR    8'h04
`define REG_IRQ_STAT    8'h08
`define REG_IRQ_MASK    8'h0C
`define REG_IO_STAT     8'h10
`define REG_TIME_INF    8'h14
`define REG_TIME_WDR    8'h18
`define CTRL_REMOTE_BIT 0
`define CTRL_ADDR_LSB   8
`define CTRL_ADDR_MSB   15
`define REMOTE_RESET    1'h0
`define ADDR_RESET      8'h00
`define IRQ_REPLY_BIT   0
`define IRQ_BAD_BIT     1
`define IRQ_OUT_BIT     2
`define IRQ_WIDTH       3
`define OUT_RESET       1'h0
`define CLK_FREQ_HZ     200000000
`define TIME_TICK_MS    1
`define MS_TICKS_CALC   (`CLK_FREQ_HZ / 1000 * `TIME_TICK_MS)
`define LINE_MAX        4'hF
`endif

/* common/pump_pkg.sv */
// Types shared by the pump reporter modules.
package pump_pkg;
  typedef logic [31:0] val_t;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_INPUT, CMD_OUT_HI, CMD_OUT_LO, CMD_STATUS, CMD_BAD
  } cmd_t;
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_HEAD   = 8'h02,
    ST_TEXT   = 8'h04,
    ST_NSTART = 8'h08,
    ST_NUM    = 8'h10,
    ST_SPACE  = 8'h20,
    ST_FLAG   = 8'h40,
    ST_END    = 8'h80
  } state_t;
endpackage

/* common/pump_links.sv */
// Interfaces between the reporter and its parser and decimal converter.
`timescale 1ns/100ps
`default_nettype none
interface cmd_if;
  import pump_pkg::*;
  logic valid;
  cmd_t code;
  modport src (output valid, output code);
  modport dst (input valid, input code);
endinterface

interface dec_if;
  import pump_pkg::*;
  logic       start;
  val_t       value;
  logic [7:0] digit;
  logic       dvalid;
  logic       dready;
  logic       dlast;
  logic       busy;
  modport conv (input start, input value, input dready,
                output digit, output dvalid, output dlast, output busy);
  modport user (output start, output value, output dready,
                input digit, input dvalid, input dlast, input busy);
endinterface
`default_nettype wire

/* logic/pump_parser.sv */
// Line collector that turns received text into command codes.
`timescale 1ns/100ps
`default_nettype none
`include "pump_consts.svh"
module pump_parser
  import pump_pkg::*;
(
  input  wire logic       clk_i,     // Clock.
  input  wire logic       rst_i,     // Synchronous reset, active high.
  input  wire logic [7:0] rx_data_i, // Received character.
  input  wire logic       rx_take_i, // Character accepted this cycle.
  cmd_if.src              link       // Decoded command pulse.
);
  logic [103:0] buf_r;
  logic [3:0]   len_r;
  logic         valid_r;
  cmd_t         code_r;

  wire       is_end = (rx_data_i == 8'h0D) | (rx_data_i == 8'h0A);
  // Case is folded so that the host may type commands in either case.
  wire [7:0] low_ch = ((rx_data_i >= "A") & (rx_data_i <= "Z")) ? (rx_data_i | 8'h20) : rx_data_i;
  wire       m_in   = (len_r == 4'h5) & (buf_r[39:0] == "input");
  wire       m_st   = (len_r == 4'h6) & (buf_r[47:0] == "status");
  wire       m_hi   = (len_r == 4'hD) & (buf_r[103:0] == "output 1 high");
  wire       m_lo   = (len_r == 4'hC) & (buf_r[95:0] == "output 1 low");
  wire cmd_t line_cmd = m_in ? CMD_INPUT : m_st ? CMD_STATUS : m_hi ? CMD_OUT_HI :
                        m_lo ? CMD_OUT_LO : CMD_BAD;

  assign link.valid = valid_r;
  assign link.code  = code_r;

  always_ff @(posedge clk_i) begin
    valid_r <= 1'b0;
    if (rst_i) begin
      buf_r  <= '0;
      len_r  <= 4'h0;
      code_r <= CMD_NONE;
    end else if (rx_take_i & is_end) begin
      // An empty line is dropped silently; an over-long one is reported as bad.
      valid_r <= (len_r != 4'h0);
      code_r  <= line_cmd;
      buf_r   <= '0;
      len_r   <= 4'h0;
    end else if (rx_take_i) begin
      buf_r <= {buf_r[95:0], low_ch};
      len_r <= (len_r == `LINE_MAX) ? len_r : len_r + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* logic/pump_decimal.sv */
// Binary to unpadded decimal ASCII converter, most significant digit first.
`timescale 1ns/100ps
`default_nettype none
module pump_decimal (
  input  wire logic clk_i, // Clock.
  input  wire logic rst_i, // Synchronous reset, active high.
  dec_if.conv       port   // Value in, digit stream out.
);
  logic [31:0] val_r;
  logic [3:0]  pos_r;
  logic [3:0]  dig_r;
  logic        seen_r;
  logic        run_r;

  function automatic logic [31:0] pow10(input logic [3:0] p);
    case (p)
      4'h0:    pow10 = 32'h0000_0001;
      4'h1:    pow10 = 32'h0000_000A;
      4'h2:    pow10 = 32'h0000_0064;
      4'h3:    pow10 = 32'h0000_03E8;
      4'h4:    pow10 = 32'h0000_2710;
      4'h5:    pow10 = 32'h0001_86A0;
      4'h6:    pow10 = 32'h000F_4240;
      4'h7:    pow10 = 32'h0098_9680;
      4'h8:    pow10 = 32'h05F5_E100;
      default: pow10 = 32'h3B9A_CA00;
    endcase
  endfunction

  // Repeated subtraction keeps the logic small; a full value takes up to about 95 cycles.
  wire [31:0] pw    = pow10(pos_r);
  wire        ge    = val_r >= pw;
  wire        shows = (dig_r != 4'h0) | seen_r | (pos_r == 4'h0);

  assign port.dvalid = run_r & ~ge & shows;
  assign port.digit  = {4'h3, dig_r};
  assign port.dlast  = (pos_r == 4'h0);
  assign port.busy   = run_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r  <= 1'b0;
      val_r  <= '0;
      pos_r  <= 4'h0;
      dig_r  <= 4'h0;
      seen_r <= 1'b0;
    end else if (port.start & ~run_r) begin
      val_r  <= port.value;
      pos_r  <= 4'h9;
      dig_r  <= 4'h0;
      seen_r <= 1'b0;
      run_r  <= 1'b1;
    end else if (run_r & ge) begin
      val_r <= val_r - pw;
      dig_r <= dig_r + 4'h1;
    end else if (run_r & (~shows | port.dready)) begin
      seen_r <= seen_r | shows;
      dig_r  <= 4'h0;
      if (pos_r == 4'h0) begin
        run_r <= 1'b0;
      end else begin
        pos_r <= pos_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/pump_reporter_chk.sv */
// Port checker of the pump reporter.
`timescale 1ns/100ps
`default_nettype none
module pump_reporter_chk (
  input wire logic        clk_i,      // Clock.
  input wire logic        rst_i,      // Reset.
  input wire logic        wb_cyc_i,   // Cycle.
  input wire logic        wb_stb_i,   // Strobe.
  input wire logic        wb_we_i,    // Write.
  input wire logic [7:0]  wb_adr_i,   // Address.
  input wire logic [31:0] wb_dat_o,   // Read data.
  input wire logic        wb_ack_o,   // Ack.
  input wire logic        rx_valid_i, // Char valid.
  input wire logic        rx_ready_o, // Char taken.
  input wire logic [7:0]  tx_data_o,  // Reply char.
  input wire logic        tx_valid_o, // Reply valid.
  input wire logic        tx_ready_i, // Reply taken.
  input wire logic        out_port_o, // Output port.
  input wire logic        irq_o       // Interrupt.
);
  // ====
  // Assertions.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  chk_ack_pulse: assert property (wb_ack_o |=> (!wb_ack_o && !(wb_cyc_i && wb_stb_i)))
    else $error("ack too long");
  chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i >= 8'h1C
    |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  chk_reset_quiet: assert property ($fell(rst_i)
    |-> !tx_valid_o && !out_port_o && !irq_o && !wb_ack_o && rx_ready_o) else $error("reset");
  chk_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply char dropped");
  chk_rx_busy: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("input taken during reply");
  chk_out_cause: assert property ($changed(out_port_o)
    |-> $past(rx_valid_i, 2) || $past(rx_valid_i, 3) || $past(rx_valid_i, 4)) else $error("port");
  chk_ascii_only: assert property (tx_valid_o
    |-> tx_data_o inside {[8'h20:8'h7E], 8'h0A, 8'h0D}) else $error("bad reply char");
  cov_read: cover property (wb_ack_o && !wb_we_i);
  cov_tx_stall: cover property (tx_valid_o && !tx_ready_i ##1 tx_ready_i);
  cov_out_rise: cover property ($rose(out_port_o));
endmodule
bind pump_reporter pump_reporter_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .rx_valid_i, .rx_ready_o, .tx_data_o, .tx_valid_o,
  .tx_ready_i, .out_port_o, .irq_o);
`default_nettype wire

/* verif/pump_host.sv */
// Host computer model: sends command lines and gathers reply characters.
`timescale 1ns/100ps
`default_nettype none
module pump_host (
  input  wire logic       clk_i,      // Clock.
  input  wire logic       rx_ready_o, // Device takes a char.
  input  wire logic [7:0] tx_data_o,  // Reply char.
  input  wire logic       tx_valid_o, // Reply valid.
  output logic      [7:0] rx_data_i,  // Command char.
  output logic            rx_valid_i, // Command valid.
  output logic            tx_ready_i  // Reply taken.
);
  string      got = "";
  bit         slow = 1'b0;
  logic [1:0] cnt = 2'h0;
  initial begin
    rx_data_i = 8'h00;
    rx_valid_i = 1'b0;
    tx_ready_i = 1'b0;
  end
  // ====
  // Slow mode takes one char in four, so the device must hold each one.
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    tx_ready_i <= !slow || cnt == 2'h3;
    if (tx_valid_o && tx_ready_i) got = $sformatf("%s%c", got, tx_data_o);
  end
  task automatic send(input string s);
    foreach (s[i]) begin
      rx_data_i <= s[i];
      rx_valid_i <= 1'b1;
      do begin
        @(posedge clk_i);
      end while (rx_ready_o !== 1'b1);
    end
    rx_valid_i <= 1'b0;
    rx_data_i <= ~rx_data_i;
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench of the pump reporter.
`timescale 1ns/100ps
`default_nettype none
`include "pump_consts.svh"
module tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, rx_data_i, tx_data_o;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
  logic        wb_ack_o, rx_ready_o, tx_valid_o, tx_ready_i, rx_valid_i, out_port_o, irq_o;
  logic [31:0] rate_inf_i = 32'h0000_0007, rate_wdr_i = 32'h0000_04D2;
  logic [31:0] vol_inf_i = 32'h0000_0063, vol_wdr_i = 32'h0000_0038;
  logic        motor_dir_i = 1'b1, motor_run_i = 1'b0, limit_inf_i = 1'b0, limit_wdr_i = 1'b1;
  logic        stall_i = 1'b1, trigger_i = 1'b1, dir_port_i = 1'b1, target_hit_i = 1'b1;
  int          n_mismatch = 0, total_checks = 0;
  always #2.5 clk_i = ~clk_i;
  pump_reporter #(.MS_TICKS(20)) u_dut (.*);
  pump_host u_host (.*);
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [255:0] pk(input string s);
    pk = '0;
    foreach (s[i]) pk = {pk[247:0], s[i]};
  endfunction
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hF};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic run(input string c, input string e);
    u_host.got = "";
    u_host.send({c, "\r"});
    repeat (8) @(posedge clk_i);
    while (rx_ready_o !== 1'b1) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    check(pk(u_host.got), pk(e));
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ====
  // Test sequence.
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, 8'h40, '0);
    check(q, '0);
    bus(1'b0, `REG_CTRL, '0);
    check(q, '0);
    $display("test registers done");
    bus(1'b1, `REG_IRQ_MASK, 32'h0000_0004);
    run("output 1 high", "");
    check(out_port_o, 1'b1);
    check(irq_o, 1'b1);
    bus(1'b0, `REG_IRQ_STAT, '0);
    check(q, 32'h0000_0004);
    check(irq_o, 1'b0);
    run("OUTPUT 1 LOW", "");
    check(out_port_o, 1'b0);
    bus(1'b0, `REG_IO_STAT, '0);
    check(q, 32'h0000_000A);
    $display("test output done");
    run("input", "\nHigh.\r");
    trigger_i <= 1'b0;
    run("input", "\nLow.\r");
    u_host.slow = 1'b1;
    trigger_i <= 1'b1;
    run("status", "1234 0 56 wwSTwT\r\n");
    {motor_dir_i, limit_wdr_i, stall_i, trigger_i, target_hit_i, dir_port_i} <= 6'b000000;
    run("status", "7 0 99 i...i.\r\n");
    u_host.slow = 1'b0;
    $display("test status done");
    {motor_dir_i, motor_run_i} <= 2'b11;
    repeat (400) @(posedge clk_i);
    motor_run_i <= 1'b0;
    bus(1'b0, `REG_TIME_WDR, '0);
    check(q inside {32'd19, 32'd20}, 1'b1);
    bus(1'b1, `REG_TIME_CLR, 32'h0000_0002);
    bus(1'b0, `REG_TIME_WDR, '0);
    check(q, '0);
    run("status", "1234 0 56 w...i.\r\n");
    $display("test time done");
    run("bogus", "\n?\r");
    bus(1'b0, `REG_IRQ_STAT, '0);
    check(q, 32'h0000_0007);
    bus(1'b1, `REG_CTRL, 32'h0000_0501);
    bus(1'b0, `REG_CTRL, '0);
    check(q, 32'h0000_0501);
    run("input", "\n05: Low.");
    $display("test remote done");
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    wrap_up;
  end
endmodule
`default_nettype wire
